/* File: core/paq_top.sv */
// Action qualifier of one PWM channel with its time base and APB register file.
`timescale 1ns/100ps
module paq_top (
    input  wire logic        I_CLOCK,
    input  wire logic        I_SYS_RST,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    output logic             O_PWM_OUTPUT_A,
    output logic             O_PWM_OUTPUT_B
);

    localparam int W = paq_pkg::CNT_W;

    paq_pkg::paq_state_type st_r;
    paq_pkg::paq_state_type st_nxt;
    paq_pkg::paq_ev_type    ev_a;
    paq_pkg::paq_ev_type    ev_b;
    paq_pkg::paq_sel_type   sel_a;
    paq_pkg::paq_sel_type   sel_b;
    logic [1:0]             compare_a_value_ev;
    logic [1:0]             compare_b_value_ev;
    logic                   counting;
    logic                   prio_up;
    logic                   at_zero;
    logic                   at_prd;
    logic                   level_a;
    logic                   level_b;
    logic                   access;

    // Returns {up_event, down_event} for one compare value.
    function automatic logic [1:0] cmp_events(input paq_pkg::paq_mode_type mode,
                                              input logic dir_up,
                                              input logic [W-1:0] cnt,
                                              input logic [W-1:0] prd,
                                              input logic [W-1:0] cmp);
        logic up;
        logic dn;
        up = 1'b0;
        dn = 1'b0;
        case (mode)
            paq_pkg::MODE_UP: begin
                up = (cmp <= prd) && (cnt == cmp);
            end
            paq_pkg::MODE_DOWN: begin
                dn = (cmp < prd) ? (cnt == cmp) : (cnt == prd);
            end
            paq_pkg::MODE_UPDOWN: begin
                if (cmp < prd) begin
                    up = dir_up && (cnt == cmp);
                    dn = !dir_up && (cnt == cmp);
                end else begin
                    up = (cnt == prd);
                    dn = (cnt == prd);
                end
            end
            default: begin
                up = 1'b0;
                dn = 1'b0;
            end
        endcase
        return {up, dn};
    endfunction : cmp_events

    // Orders the events of one output by the priority of the current mode.
    function automatic paq_pkg::paq_sel_type order_events(input paq_pkg::paq_mode_type mode,
                                                         input logic rising,
                                                         input paq_pkg::paq_ev_type ev,
                                                         input paq_pkg::paq_cfg_type cfg,
                                                         input paq_pkg::paq_act_type frc);
        paq_pkg::paq_sel_type s;
        s.hit    = 7'h00;
        s.act    = '{default: paq_pkg::ACT_NONE};
        s.hit[0] = ev.sw;
        s.act[0] = frc;
        case (mode)
            paq_pkg::MODE_UP: begin
                s.hit[6:1] = {1'b0, 1'b0, ev.zero, ev.cmp_a_up_match, ev.cmp_b_up_match, ev.period};
                s.act[1]   = cfg.period;
                s.act[2]   = cfg.cmp_b_up_match;
                s.act[3]   = cfg.cmp_a_up_match;
                s.act[4]   = cfg.zero;
            end
            paq_pkg::MODE_DOWN: begin
                s.hit[6:1] = {1'b0, 1'b0, ev.period, ev.cad, ev.cbd, ev.zero};
                s.act[1]   = cfg.zero;
                s.act[2]   = cfg.cbd;
                s.act[3]   = cfg.cad;
                s.act[4]   = cfg.period;
            end
            paq_pkg::MODE_UPDOWN: begin
                if (rising) begin
                    s.hit[6:1] = {ev.period, ev.cad, ev.cbd, ev.zero, ev.cmp_a_up_match, ev.cmp_b_up_match};
                    s.act[1]   = cfg.cmp_b_up_match;
                    s.act[2]   = cfg.cmp_a_up_match;
                    s.act[3]   = cfg.zero;
                    s.act[4]   = cfg.cbd;
                    s.act[5]   = cfg.cad;
                    s.act[6]   = cfg.period;
                end else begin
                    s.hit[6:1] = {ev.zero, ev.cmp_a_up_match, ev.cmp_b_up_match, ev.period, ev.cad, ev.cbd};
                    s.act[1]   = cfg.cbd;
                    s.act[2]   = cfg.cad;
                    s.act[3]   = cfg.period;
                    s.act[4]   = cfg.cmp_b_up_match;
                    s.act[5]   = cfg.cmp_a_up_match;
                    s.act[6]   = cfg.zero;
                end
            end
            default: begin
                s.hit[6:1] = 6'h00;
            end
        endcase
        return s;
    endfunction : order_events

    function automatic logic addr_mapped(input logic [7:0] addr);
        return (addr == paq_pkg::ADDR_CTRL) || (addr == paq_pkg::ADDR_PERIOD) ||
               (addr == paq_pkg::ADDR_COMPARE_A_VALUE) || (addr == paq_pkg::ADDR_COMPARE_B_VALUE) ||
               (addr == paq_pkg::ADDR_ACT_A) || (addr == paq_pkg::ADDR_ACT_B) ||
               (addr == paq_pkg::ADDR_FORCE) || (addr == paq_pkg::ADDR_STATUS) ||
               (addr == paq_pkg::ADDR_ACT_CMP) || (addr == paq_pkg::ADDR_ACT_PRD);
    endfunction : addr_mapped

    function automatic logic [31:0] read_mux(input paq_pkg::paq_state_type s, input logic [7:0] addr);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (addr == paq_pkg::ADDR_CTRL) begin
            d[3:0] = {s.run, s.load_prd, s.mode};
        end else if (addr == paq_pkg::ADDR_PERIOD) begin
            d[W-1:0] = s.prd_sh;
        end else if (addr == paq_pkg::ADDR_COMPARE_A_VALUE) begin
            d[W-1:0] = s.compare_a_value_sh;
        end else if (addr == paq_pkg::ADDR_COMPARE_B_VALUE) begin
            d[W-1:0] = s.compare_b_value_sh;
        end else if (addr == paq_pkg::ADDR_ACT_A) begin
            d[paq_pkg::ACT_CFG_W-1:0] = s.cfg_a;
        end else if (addr == paq_pkg::ADDR_ACT_B) begin
            d[paq_pkg::ACT_CFG_W-1:0] = s.cfg_b;
        end else if (addr == paq_pkg::ADDR_FORCE) begin
            d[3:0] = {s.frc_b, s.frc_a};
        end else if (addr == paq_pkg::ADDR_STATUS) begin
            d[W+2:0] = {s.out_b, s.out_a, s.dir_up, s.cnt};
        end else if (addr == paq_pkg::ADDR_ACT_CMP) begin
            d = {s.compare_b_value_act, s.compare_a_value_act};
        end else if (addr == paq_pkg::ADDR_ACT_PRD) begin
            d[W-1:0] = s.prd_act;
        end
        return d;
    endfunction : read_mux

    // Event generation; every comparison uses the active copies only.
    always_comb begin
        counting = st_r.run && (st_r.mode != paq_pkg::MODE_STOP);
        at_zero  = (st_r.cnt == {W{1'b0}});
        at_prd   = (st_r.cnt == st_r.prd_act);
        // The zero point belongs to the rising half, the period to whichever way the counter came.
        prio_up  = at_zero || st_r.dir_up;
        compare_a_value_ev  = cmp_events(st_r.mode, st_r.dir_up, st_r.cnt, st_r.prd_act, st_r.compare_a_value_act);
        compare_b_value_ev  = cmp_events(st_r.mode, st_r.dir_up, st_r.cnt, st_r.prd_act, st_r.compare_b_value_act);
        ev_a.sw     = st_r.fire_a;
        ev_a.zero   = counting && at_zero;
        ev_a.period = counting && at_prd;
        ev_a.cmp_a_up_match    = counting && compare_a_value_ev[1];
        ev_a.cad    = counting && compare_a_value_ev[0];
        ev_a.cmp_b_up_match    = counting && compare_b_value_ev[1];
        ev_a.cbd    = counting && compare_b_value_ev[0];
        ev_b        = ev_a;
        ev_b.sw     = st_r.fire_b;
        sel_a = order_events(st_r.mode, prio_up, ev_a, st_r.cfg_a, st_r.frc_a);
        sel_b = order_events(st_r.mode, prio_up, ev_b, st_r.cfg_b, st_r.frc_b);
    end

    paq_resolve u_resolve_a (
        .i_sel   (sel_a),
        .i_level (st_r.out_a),
        .o_level (level_a)
    );

    paq_resolve u_resolve_b (
        .i_sel   (sel_b),
        .i_level (st_r.out_b),
        .o_level (level_b)
    );

    always_comb begin
        st_nxt = st_r;
        access = I_PSEL && I_PENABLE;
        st_nxt.out_a   = level_a;
        st_nxt.out_b   = level_b;
        // A force is a one-cycle event; a fresh write below may raise it again.
        st_nxt.fire_a  = 1'b0;
        st_nxt.fire_b  = 1'b0;
        st_nxt.pready  = 1'b0;
        st_nxt.pslverr = 1'b0;

        // Time base.
        if (counting) begin
            case (st_r.mode)
                paq_pkg::MODE_UP: begin
                    st_nxt.dir_up = 1'b1;
                    // A lowered period must not leave the counter stranded above it.
                    st_nxt.cnt = (st_r.cnt >= st_r.prd_act) ? {W{1'b0}} : W'(st_r.cnt + 1'b1);
                end
                paq_pkg::MODE_DOWN: begin
                    st_nxt.dir_up = 1'b0;
                    st_nxt.cnt = (at_zero || st_r.cnt > st_r.prd_act) ? st_r.prd_act : W'(st_r.cnt - 1'b1);
                end
                default: begin
                    // Direction flips as the counter leaves an end, so zero is reached falling.
                    if (st_r.dir_up) begin
                        if (st_r.cnt >= st_r.prd_act) begin
                            st_nxt.dir_up = 1'b0;
                            st_nxt.cnt    = at_zero ? st_r.cnt : W'(st_r.cnt - 1'b1);
                        end else begin
                            st_nxt.cnt = W'(st_r.cnt + 1'b1);
                        end
                    end else if (at_zero) begin
                        st_nxt.dir_up = 1'b1;
                        st_nxt.cnt    = (st_r.prd_act == {W{1'b0}}) ? st_r.cnt : W'(st_r.cnt + 1'b1);
                    end else begin
                        st_nxt.cnt = W'(st_r.cnt - 1'b1);
                    end
                end
            endcase
            if (at_zero) begin
                st_nxt.prd_act = st_r.prd_sh;
            end
            if (st_r.load_prd ? at_prd : at_zero) begin
                st_nxt.compare_a_value_act = st_r.compare_a_value_sh;
                st_nxt.compare_b_value_act = st_r.compare_b_value_sh;
            end
        end

        // APB slave: one wait state, then the transfer completes.
        if (access && !st_r.pready) begin
            st_nxt.pready  = 1'b1;
            st_nxt.pslverr = !addr_mapped(I_PADDR);
            st_nxt.prdata  = I_PWRITE ? 32'h0000_0000 : read_mux(st_r, I_PADDR);
        end
        if (access && st_r.pready && I_PWRITE) begin
            if (I_PADDR == paq_pkg::ADDR_CTRL) begin
                st_nxt.mode     = paq_pkg::paq_mode_type'(I_PWDATA[paq_pkg::CTRL_MODE_LSB +: 2]);
                st_nxt.load_prd = I_PWDATA[paq_pkg::CTRL_LOAD_PRD];
                st_nxt.run      = I_PWDATA[paq_pkg::CTRL_RUN];
            end else if (I_PADDR == paq_pkg::ADDR_PERIOD) begin
                st_nxt.prd_sh = I_PWDATA[W-1:0];
            end else if (I_PADDR == paq_pkg::ADDR_COMPARE_A_VALUE) begin
                st_nxt.compare_a_value_sh = I_PWDATA[W-1:0];
            end else if (I_PADDR == paq_pkg::ADDR_COMPARE_B_VALUE) begin
                st_nxt.compare_b_value_sh = I_PWDATA[W-1:0];
            end else if (I_PADDR == paq_pkg::ADDR_ACT_A) begin
                st_nxt.cfg_a = paq_pkg::paq_cfg_type'(I_PWDATA[paq_pkg::ACT_CFG_W-1:0]);
            end else if (I_PADDR == paq_pkg::ADDR_ACT_B) begin
                st_nxt.cfg_b = paq_pkg::paq_cfg_type'(I_PWDATA[paq_pkg::ACT_CFG_W-1:0]);
            end else if (I_PADDR == paq_pkg::ADDR_FORCE) begin
                st_nxt.frc_a  = paq_pkg::paq_act_type'(I_PWDATA[paq_pkg::FRC_A_LSB +: 2]);
                st_nxt.frc_b  = paq_pkg::paq_act_type'(I_PWDATA[paq_pkg::FRC_B_LSB +: 2]);
                st_nxt.fire_a = I_PWDATA[paq_pkg::FRC_FIRE_A];
                st_nxt.fire_b = I_PWDATA[paq_pkg::FRC_FIRE_B];
            end
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            st_r          <= '0;
            st_r.mode     <= paq_pkg::RST_MODE;
            st_r.prd_sh   <= paq_pkg::RST_PRD;
            st_r.prd_act  <= paq_pkg::RST_PRD;
            st_r.compare_a_value_sh  <= paq_pkg::RST_CMP;
            st_r.compare_a_value_act <= paq_pkg::RST_CMP;
            st_r.compare_b_value_sh  <= paq_pkg::RST_CMP;
            st_r.compare_b_value_act <= paq_pkg::RST_CMP;
            st_r.dir_up   <= 1'b1;
            st_r.cfg_a    <= '{default: paq_pkg::ACT_NONE};
            st_r.cfg_b    <= '{default: paq_pkg::ACT_NONE};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign O_PRDATA       = st_r.prdata;
    assign O_PREADY       = st_r.pready;
    assign O_PSLVERR      = st_r.pslverr;
    assign O_PWM_OUTPUT_A = st_r.out_a;
    assign O_PWM_OUTPUT_B = st_r.out_b;

    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (I_SYS_RST);

    sw_force_wins_a: assert property (
        (st_r.fire_a && st_r.frc_a == paq_pkg::ACT_TOGGLE) |=> (st_r.out_a != $past(st_r.out_a)))
        else $error("Forced toggle on output A did not take effect.");

    updown_rise_prio_a: assert property (
        (st_r.mode == paq_pkg::MODE_UPDOWN && prio_up && !st_r.fire_a && ev_a.cmp_b_up_match
         && st_r.cfg_a.cmp_b_up_match == paq_pkg::ACT_SET) |=> st_r.out_a)
        else $error("Rising compare B action lost to a lower event.");

    updown_fall_prio_a: assert property (
        (st_r.mode == paq_pkg::MODE_UPDOWN && !prio_up && !st_r.fire_a && ev_a.cbd
         && st_r.cfg_a.cbd == paq_pkg::ACT_CLEAR) |=> !st_r.out_a)
        else $error("Falling compare B action lost to a lower event.");

    both_dir_period_a: assert property (
        (ev_a.cmp_a_up_match && ev_a.cad) |-> (st_r.cnt == st_r.prd_act))
        else $error("Both compare A directions fired away from the period.");

    up_period_prio_a: assert property (
        (st_r.mode == paq_pkg::MODE_UP && ev_a.period && !st_r.fire_a
         && st_r.cfg_a.period == paq_pkg::ACT_SET) |=> st_r.out_a)
        else $error("Up mode period action did not win.");

    up_no_down_a: assert property (
        (st_r.mode == paq_pkg::MODE_UP) |-> !(ev_a.cad || ev_a.cbd))
        else $error("Down compare event in up mode.");

    down_zero_prio_a: assert property (
        (st_r.mode == paq_pkg::MODE_DOWN && ev_a.zero && !st_r.fire_a
         && st_r.cfg_a.zero == paq_pkg::ACT_CLEAR) |=> !st_r.out_a)
        else $error("Down mode zero action did not win.");

    down_no_up_a: assert property (
        (st_r.mode == paq_pkg::MODE_DOWN) |-> !(ev_a.cmp_a_up_match || ev_a.cmp_b_up_match))
        else $error("Up compare event in down mode.");

    up_cmp_above_a: assert property (
        (st_r.mode == paq_pkg::MODE_UP && st_r.compare_a_value_act > st_r.prd_act) |-> !ev_a.cmp_a_up_match)
        else $error("Compare above period produced an up event.");

    down_cmp_period_a: assert property (
        (st_r.mode == paq_pkg::MODE_DOWN && counting && at_prd && st_r.compare_a_value_act >= st_r.prd_act) |-> ev_a.cad)
        else $error("Large compare did not fire at the period in down mode.");

    cmp_reload_zero_a: assert property (
        (counting && at_zero && !st_r.load_prd) |=> (st_r.compare_a_value_act == $past(st_r.compare_a_value_sh)))
        else $error("Compare A not reloaded at zero.");

    up_wrap_zero_a: assert property (
        (st_r.mode == paq_pkg::MODE_UP && counting && at_prd) |=> (st_r.cnt == {W{1'b0}}))
        else $error("Up counter did not wrap from period to zero in one tick.");

endmodule : paq_top

/* File: pkg/paq_pkg.sv */
// Shared constants, register map and carrier types for the PWM action qualifier.
package paq_pkg;

    localparam int          CNT_W = 16;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_PERIOD   = 8'h04;
    localparam logic [7:0] ADDR_COMPARE_A_VALUE     = 8'h08;
    localparam logic [7:0] ADDR_COMPARE_B_VALUE     = 8'h0c;
    localparam logic [7:0] ADDR_ACT_A    = 8'h10;
    localparam logic [7:0] ADDR_ACT_B    = 8'h14;
    localparam logic [7:0] ADDR_FORCE    = 8'h18;
    localparam logic [7:0] ADDR_STATUS   = 8'h1c;
    localparam logic [7:0] ADDR_ACT_CMP  = 8'h20;
    localparam logic [7:0] ADDR_ACT_PRD  = 8'h24;

    // Field positions.
    localparam int          CTRL_MODE_LSB   = 0;
    localparam int          CTRL_LOAD_PRD   = 2;
    localparam int          CTRL_RUN        = 3;
    localparam int          FRC_A_LSB       = 0;
    localparam int          FRC_B_LSB       = 2;
    localparam int          FRC_FIRE_A      = 4;
    localparam int          FRC_FIRE_B      = 5;
    localparam int          ACT_CFG_W       = 12;

    typedef enum logic [1:0] {
        MODE_UP     = 2'h0,
        MODE_DOWN   = 2'h1,
        MODE_UPDOWN = 2'h2,
        MODE_STOP   = 2'h3
    } paq_mode_type;

    typedef enum logic [1:0] {
        ACT_NONE   = 2'h0,
        ACT_CLEAR  = 2'h1,
        ACT_SET    = 2'h2,
        ACT_TOGGLE = 2'h3
    } paq_act_type;

    // Per-output action for each counter event; zero sits in the low bits.
    typedef struct packed {
        paq_act_type cbd;
        paq_act_type cmp_b_up_match;
        paq_act_type cad;
        paq_act_type cmp_a_up_match;
        paq_act_type period;
        paq_act_type zero;
    } paq_cfg_type;

    typedef struct packed {
        logic sw;
        logic zero;
        logic period;
        logic cmp_a_up_match;
        logic cad;
        logic cmp_b_up_match;
        logic cbd;
    } paq_ev_type;

    // Events and their actions in priority order, slot 0 the highest.
    typedef struct packed {
        logic [6:0]       hit;
        paq_act_type [6:0] act;
    } paq_sel_type;

    typedef struct packed {
        paq_mode_type       mode;
        logic               load_prd;
        logic               run;
        logic [CNT_W-1:0]   prd_sh;
        logic [CNT_W-1:0]   prd_act;
        logic [CNT_W-1:0]   compare_a_value_sh;
        logic [CNT_W-1:0]   compare_a_value_act;
        logic [CNT_W-1:0]   compare_b_value_sh;
        logic [CNT_W-1:0]   compare_b_value_act;
        logic [CNT_W-1:0]   cnt;
        logic               dir_up;
        paq_cfg_type        cfg_a;
        paq_cfg_type        cfg_b;
        paq_act_type        frc_a;
        paq_act_type        frc_b;
        logic               fire_a;
        logic               fire_b;
        logic               out_a;
        logic               out_b;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
    } paq_state_type;

    localparam paq_mode_type     RST_MODE = MODE_UP;
    localparam logic [CNT_W-1:0] RST_PRD  = 16'h0000;
    localparam logic [CNT_W-1:0] RST_CMP  = 16'h0000;

endpackage : paq_pkg

/* File: core/paq_resolve.sv */
// Picks the highest-priority event whose action is not none for one output and applies that action.
`timescale 1ns/100ps
module paq_resolve (
    input  wire paq_pkg::paq_sel_type i_sel,
    input  wire logic                 i_level,
    output logic                      o_level
);

    paq_pkg::paq_act_type chosen;
    logic                 any_hit;

    always_comb begin
        chosen  = paq_pkg::ACT_NONE;
        any_hit = 1'b0;
        // Walk from lowest to highest so the last hit standing wins.
        // A do-nothing event takes no part, or zero would mask the down-match clear that keeps 0% duty low.
        for (int i = 6; i >= 0; i--) begin
            if (i_sel.hit[i] && (i_sel.act[i] != paq_pkg::ACT_NONE)) begin
                chosen  = i_sel.act[i];
                any_hit = 1'b1;
            end
        end
        o_level = i_level;
        if (any_hit) begin
            case (chosen)
                paq_pkg::ACT_CLEAR:  o_level = 1'b0;
                paq_pkg::ACT_SET:    o_level = 1'b1;
                paq_pkg::ACT_TOGGLE: o_level = ~i_level;
                default:             o_level = i_level;
            endcase
        end
    end

endmodule : paq_resolve

/* File: verif/paq_sink.sv */
// Behavioural sink that counts high cycles of each PWM output while enabled.
`timescale 1ns/100ps
module paq_sink (
    input  wire logic i_clk,
    input  wire logic i_clr,
    input  wire logic i_en,
    input  wire logic i_a,
    input  wire logic i_b,
    output int        o_hi_a,
    output int        o_hi_b
);
    // Counting only inside a window keeps the result independent of the counter phase.
    always @(posedge i_clk) begin
        if (i_clr) begin
            o_hi_a <= 0;
            o_hi_b <= 0;
        end else if (i_en) begin
            o_hi_a <= o_hi_a + (i_a === 1'b1);
            o_hi_b <= o_hi_b + (i_b === 1'b1);
        end
    end
endmodule : paq_sink

/* File: verif/paq_top_tb.sv */
// Self-checking testbench for the PWM action qualifier.
`timescale 1ns/100ps
module paq_top_tb;
    logic clk, rst, psel, pen, pwr, clr, en;
    logic [7:0] pa;
    logic [31:0] pwd, prd, q;
    logic rdy, err, oa, ob, e;
    int ha, hb, fails, checked;
    paq_top i_paq_top (.I_CLOCK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err),
        .O_PWM_OUTPUT_A(oa), .O_PWM_OUTPUT_B(ob));
    paq_sink i_paq_sink (.i_clk(clk), .i_clr(clr), .i_en(en), .i_a(oa), .i_b(ob), .o_hi_a(ha), .o_hi_b(hb));
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1;
        do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 20);
        q = prd;
        e = err;
        psel <= 0; pen <= 0;
        if (rdy !== 1'b1) chk(0, 1);
    endtask : apb
    task automatic meas(input int settle, input int n);
        repeat (settle) @(posedge clk);
        clr <= 1;
        @(posedge clk);
        clr <= 0; en <= 1;
        repeat (n) @(posedge clk);
        en <= 0;
        @(posedge clk);
    endtask : meas
    task automatic t_regs;
        apb(0, paq_pkg::ADDR_STATUS, 0); chk(q, 32'h0001_0000);
        apb(1, paq_pkg::ADDR_STATUS, 32'hffff_ffff); apb(0, paq_pkg::ADDR_STATUS, 0); chk(q, 32'h0001_0000);
        apb(0, 8'h30, 0); chk(q, 32'h0000_0000); chk(e, 1'b1);
        apb(1, paq_pkg::ADDR_PERIOD, 3); apb(1, paq_pkg::ADDR_CTRL, 8);
        meas(12, 8); chk(ha + hb, 0);
        apb(0, paq_pkg::ADDR_ACT_PRD, 0); chk(q, 32'h0000_0003);
    endtask : t_regs
    task automatic t_up;
        apb(1, paq_pkg::ADDR_CTRL, 32'hc);
        apb(1, paq_pkg::ADDR_COMPARE_A_VALUE, 2); apb(1, paq_pkg::ADDR_ACT_A, 12'h012);
        meas(16, 8); chk(ha, 4);
        apb(0, paq_pkg::ADDR_ACT_CMP, 0); chk(q, 32'h0000_0002);
        apb(1, paq_pkg::ADDR_COMPARE_A_VALUE, 4);
        meas(16, 8); chk(ha, 8);
        apb(1, paq_pkg::ADDR_COMPARE_A_VALUE, 3); apb(1, paq_pkg::ADDR_ACT_A, 12'h019);
        meas(16, 8); chk(ha, 2);
    endtask : t_up
    task automatic t_down;
        apb(1, paq_pkg::ADDR_CTRL, 9); apb(1, paq_pkg::ADDR_COMPARE_A_VALUE, 0); apb(1, paq_pkg::ADDR_ACT_A, 12'h081);
        meas(16, 8); chk(ha, 0);
        apb(1, paq_pkg::ADDR_ACT_A, 12'h042);
        meas(16, 8); chk(ha, 8);
    endtask : t_down
    task automatic t_updown;
        apb(1, paq_pkg::ADDR_CTRL, 10); apb(1, paq_pkg::ADDR_ACT_A, 12'h060);
        meas(24, 12); chk(ha, 0);
        apb(1, paq_pkg::ADDR_COMPARE_A_VALUE, 3);
        meas(24, 12); chk(ha, 12);
        apb(1, paq_pkg::ADDR_COMPARE_A_VALUE, 2);
        meas(24, 12); chk(ha, 4);
        apb(1, paq_pkg::ADDR_COMPARE_B_VALUE, 2); apb(1, paq_pkg::ADDR_ACT_A, 12'h690);
        meas(24, 12); chk(ha, 4);
        apb(1, paq_pkg::ADDR_CTRL, 32'he); apb(1, paq_pkg::ADDR_COMPARE_A_VALUE, 1); apb(1, paq_pkg::ADDR_ACT_A, 12'h024);
        meas(24, 12); chk(ha, 4);
    endtask : t_updown
    task automatic t_force;
        apb(1, paq_pkg::ADDR_CTRL, 3);
        apb(1, paq_pkg::ADDR_FORCE, 32'h3d); repeat (3) @(posedge clk); chk({oa, ob}, 2'b01);
        apb(1, paq_pkg::ADDR_FORCE, 32'h36); repeat (3) @(posedge clk); chk({oa, ob}, 2'b10);
        apb(1, paq_pkg::ADDR_FORCE, 32'h3f); repeat (3) @(posedge clk); chk({oa, ob}, 2'b01);
    endtask : t_force
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    initial begin
        fails = 0; checked = 0;
        rst = 1; psel = 0; pen = 0; pwr = 0; pa = 0; pwd = 0; clr = 1; en = 0;
        repeat (3) @(posedge clk);
        rst <= 0;
        t_regs();
        t_up();
        t_down();
        t_updown();
        t_force();
        wrap_up();
    end
    // The whole sequence needs well under a thousand cycles.
    initial begin
        #200000;
        fails++;
        wrap_up();
    end
endmodule : paq_top_tb
